// >>> src/ccu_compare_capture.sv
// Four-channel output compare and two-channel input capture unit with APB registers.
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Four compare channels with 16-bit values; active only with a non-disabled action.
// - Timer equal to compare value sets the match flag two cycles later.
// - Compare irq needs global, channel and unit enables; software clears flag with zero.
// - Compare pin action happens on every match regardless of interrupt enable.
// - Enabled channel drives its pin from a compare latch that resets to zero.
// - Writing one to force bit in basic mode toggles, or for clear sets, the latch without flag or interrupt.
// - Force bit reads zero in basic timer mode.
// - Connected pin holds its state until a match or forced compare.
// - Compare writes go to shadows; active value changes only through update bit.
// - Basic mode update copies at once and the update bit reads zero.
// - PWM mode update waits for overflow and reads one while pending.
// - One update bit moves all compare values and the reload value together.
// - Capture always enabled; an event copies the timer into the capture register.
// - Edge select zero picks falling edges, one picks rising edges.
// - Filter samples every two clocks and needs four equal samples per edge.
// - Delay code skips 0 to 5, 7 or 15 qualifying edges before capture.
// - Low byte read copies high byte to a shadow that the high read returns.
// - Action 00 off, 01 clear on match, 10 invalid, 11 toggle on match.
module ccu_compare_capture
    import ccu_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] timer_count,
    input  wire logic        timer_step,
    input  wire logic        timer_overflow,
    input  wire logic [1:0]  timer_mode,
    input  wire logic [1:0]  capture_pin,
    output logic      [3:0]  compare_pin_out,
    output logic      [3:0]  compare_pin_oe,
    output logic             compare_irq,
    output logic             capture_irq,
    output logic      [15:0] timer_reload_value
);

    // ************************************************************
    // Helper functions.
    // ************************************************************

    // Number of qualifying edges skipped before a capture.
    function automatic logic [3:0] skip_edges(input logic [2:0] code);
        unique case (code)
            3'h6:    skip_edges = 4'hF - 4'h8;
            3'h7:    skip_edges = 4'hF;
            default: skip_edges = {1'b0, code};
        endcase
    endfunction : skip_edges

    // A channel runs only with a valid, non-disabled action.
    function automatic logic action_on(input logic [1:0] act);
        action_on = (act == ACT_CLEAR) || (act == ACT_TOGGLE);
    endfunction : action_on

    // ************************************************************
    // State.
    // ************************************************************
    ccu_chan_ctrl_type ctrl_ff [4];
    logic [15:0]       cmp_shadow_ff [4];
    logic [15:0]       cmp_active_ff [4];
    logic [15:0]       reload_shadow_ff;
    logic [15:0]       reload_active_ff;
    logic              pending_ff;
    logic [7:0]        flags_ff;
    logic [7:0]        irqen_ff;
    logic [7:0]        irq_enable_register_one_ff;
    logic [3:0]        match_ff;
    logic [3:0]        latch_ff;
    logic [15:0]       cap_ff [2];
    logic [7:0]        cap_hi_shadow_ff [2];
    logic              phase_ff;
    logic [3:0]        samp_ff [2];
    logic [1:0]        level_ff;
    logic [3:0]        edge_cnt_ff [2];
    logic [31:0]       prdata_ff;

    logic       wr_acc;
    logic       rd_setup;
    logic       basic_mode;
    logic       update_wr;
    logic       copy_now;
    logic [1:0] nxt_level;
    logic [1:0] qual_edge;
    logic [1:0] cap_evt;
    logic       addr_ok;

    assign wr_acc     = psel && penable && pwrite && addr_ok;
    assign rd_setup   = psel && !penable && !pwrite;
    assign basic_mode = !timer_mode[1];
    assign update_wr  = wr_acc && (paddr == OFS_TCTRL1) && pwdata[BIT_UPDATE];
    // Stopped or basic mode copies at once; PWM modes wait for overflow.
    assign copy_now   = (update_wr && basic_mode) || (pending_ff && timer_overflow);

    // Address decode for the slave error answer.
    always_comb
    begin
        addr_ok = (paddr[1:0] == 2'h0) && (paddr <= OFS_CAP_HI_B);
    end

    // ************************************************************
    // APB slave.
    // ************************************************************

    // Zero wait states; unmapped access answers with an error.
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign prdata  = prdata_ff;

    // Read data is gathered in the setup cycle and shown in the access cycle.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            prdata_ff <= 32'h0000_0000;
        else if (rd_setup)
        begin
            prdata_ff <= 32'h0000_0000;
            if (paddr < OFS_CMP0)
            begin
                prdata_ff[7:0] <= ctrl_ff[paddr[3:2]];
                prdata_ff[2]   <= ctrl_ff[paddr[3:2]].force_cmp && !basic_mode;
            end
            else if (paddr < OFS_TCTRL1)
                prdata_ff[15:0] <= cmp_shadow_ff[paddr[3:2]];
            else
                unique case (paddr)
                    OFS_TCTRL1:   prdata_ff[BIT_UPDATE] <= pending_ff;
                    OFS_RELOAD:   prdata_ff[15:0] <= reload_shadow_ff;
                    OFS_FLAGS:    prdata_ff[7:0] <= flags_ff;
                    OFS_IRQEN:    prdata_ff[7:0] <= irqen_ff;
                    OFS_IRQ_ENABLE_REGISTER_ONE:     prdata_ff[7:0] <= irq_enable_register_one_ff;
                    OFS_CAP_LO_A: prdata_ff[7:0] <= cap_ff[0][7:0];
                    OFS_CAP_HI_A: prdata_ff[7:0] <= cap_hi_shadow_ff[0];
                    OFS_CAP_LO_B: prdata_ff[7:0] <= cap_ff[1][7:0];
                    OFS_CAP_HI_B: prdata_ff[7:0] <= cap_hi_shadow_ff[1];
                    default:      prdata_ff <= 32'h0000_0000;
                endcase
        end
    end

    // Low byte reads refresh the high byte shadow.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cap_hi_shadow_ff[0] <= RST_BYTE;
            cap_hi_shadow_ff[1] <= RST_BYTE;
        end
        else if (rd_setup)
        begin
            if (paddr == OFS_CAP_LO_A)
                cap_hi_shadow_ff[0] <= cap_ff[0][15:8];
            if (paddr == OFS_CAP_LO_B)
                cap_hi_shadow_ff[1] <= cap_ff[1][15:8];
        end
    end

    // ************************************************************
    // Control and enable registers.
    // ************************************************************

    // Channel control, interrupt enables and reload shadow writes.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < 4; i++)
                ctrl_ff[i] <= ccu_chan_ctrl_type'(RST_BYTE);
            irqen_ff         <= RST_BYTE;
            irq_enable_register_one_ff          <= RST_BYTE;
            reload_shadow_ff <= RST_WORD;
        end
        else if (wr_acc)
        begin
            if (paddr < OFS_CMP0)
                ctrl_ff[paddr[3:2]] <= ccu_chan_ctrl_type'(pwdata[7:0]);
            if (paddr == OFS_IRQEN)
                irqen_ff <= pwdata[7:0];
            if (paddr == OFS_IRQ_ENABLE_REGISTER_ONE)
                irq_enable_register_one_ff <= pwdata[7:0];
            if (paddr == OFS_RELOAD)
                reload_shadow_ff <= pwdata[15:0];
        end
    end

    // ************************************************************
    // Compare values and update mechanism.
    // ************************************************************

    // Writes land in shadows; the update bit moves everything together.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < 4; i++)
            begin
                cmp_shadow_ff[i] <= RST_WORD;
                cmp_active_ff[i] <= RST_WORD;
            end
            reload_active_ff <= RST_WORD;
        end
        else
        begin
            if (wr_acc && paddr >= OFS_CMP0 && paddr < OFS_TCTRL1)
                cmp_shadow_ff[paddr[3:2]] <= pwdata[15:0];
            if (copy_now)
            begin
                for (int i = 0; i < 4; i++)
                    cmp_active_ff[i] <= cmp_shadow_ff[i];
                reload_active_ff <= reload_shadow_ff;
            end
        end
    end

    // Pending state of a deferred update in PWM modes.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            pending_ff <= 1'b0;
        else if (update_wr && !basic_mode)
            pending_ff <= 1'b1;
        else if (pending_ff && timer_overflow)
            pending_ff <= 1'b0;
    end

    assign timer_reload_value = reload_active_ff;

    // ************************************************************
    // Output compare.
    // ************************************************************

    // The timer equality is registered on each timer step.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            match_ff <= 4'h0;
        else
            for (int i = 0; i < 4; i++)
                match_ff[i] <= timer_step && (timer_count == cmp_active_ff[i])
                               && action_on(ctrl_ff[i].action);
    end

    // Compare latches change only on a match or a forced compare.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            latch_ff <= 4'h0;
        else
            for (int i = 0; i < 4; i++)
            begin
                if (match_ff[i])
                    latch_ff[i] <= (ctrl_ff[i].action == ACT_TOGGLE) ? !latch_ff[i] : 1'b0;
                else if (wr_acc && paddr == (OFS_CTRL0 + 8'(4 * i)) && pwdata[2] && basic_mode
                         && action_on(pwdata[1:0]))
                    latch_ff[i] <= (pwdata[1:0] == ACT_TOGGLE) ? !latch_ff[i] : 1'b1;
            end
    end

    // Pins are driven from the latches while their channel is enabled.
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            compare_pin_oe[i]  = action_on(ctrl_ff[i].action);
            compare_pin_out[i] = latch_ff[i] && compare_pin_oe[i];
        end
    end

    // ************************************************************
    // Input capture.
    // ************************************************************

    // Filter sampling phase: every second clock.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            phase_ff <= 1'b0;
        else
            phase_ff <= !phase_ff;
    end

    // Sample history for the noise filter.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            samp_ff[0] <= 4'h0;
            samp_ff[1] <= 4'h0;
        end
        else if (phase_ff)
            for (int c = 0; c < 2; c++)
                samp_ff[c] <= {samp_ff[c][FILT_LEN-2:0], capture_pin[c]};
    end

    // Qualified level and edge detection.
    always_comb
    begin
        for (int c = 0; c < 2; c++)
        begin
            nxt_level[c] = level_ff[c];
            if (!ctrl_ff[c].filter_en)
                nxt_level[c] = capture_pin[c];
            else if (samp_ff[c] == 4'hF || samp_ff[c] == 4'h0)
                nxt_level[c] = samp_ff[c][0];
            qual_edge[c] = (nxt_level[c] != level_ff[c]) && (nxt_level[c] == ctrl_ff[c].edge_sel);
            cap_evt[c]   = qual_edge[c] && (edge_cnt_ff[c] == skip_edges(ctrl_ff[c].delay_code));
        end
    end

    // Level history and edge counter for the delay.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            level_ff       <= 2'h0;
            edge_cnt_ff[0] <= 4'h0;
            edge_cnt_ff[1] <= 4'h0;
        end
        else
        begin
            level_ff <= nxt_level;
            for (int c = 0; c < 2; c++)
                if (cap_evt[c])
                    edge_cnt_ff[c] <= 4'h0;
                else if (qual_edge[c])
                    edge_cnt_ff[c] <= edge_cnt_ff[c] + 4'h1;
        end
    end

    // Capture registers always take the timer on an event.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cap_ff[0] <= RST_WORD;
            cap_ff[1] <= RST_WORD;
        end
        else
            for (int c = 0; c < 2; c++)
                if (cap_evt[c])
                    cap_ff[c] <= timer_count;
    end

    // ************************************************************
    // Flags and interrupt requests.
    // ************************************************************

    // Writing zero clears a flag; a new event in that cycle wins.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            flags_ff <= RST_BYTE;
        else
        begin
            for (int b = 0; b < 8; b++)
                if (wr_acc && paddr == OFS_FLAGS && !pwdata[b])
                    flags_ff[b] <= 1'b0;
            for (int i = 0; i < 4; i++)
                if (match_ff[i])
                    flags_ff[BIT_CMP0 + i] <= 1'b1;
            if (cap_evt[0])
                flags_ff[BIT_CAP_A] <= 1'b1;
            if (cap_evt[1])
                flags_ff[BIT_CAP_B] <= 1'b1;
        end
    end

    // Requests need the global, unit and per-source enables.
    always_comb
    begin
        compare_irq = irq_enable_register_one_ff[BIT_GLOB_EN] && irq_enable_register_one_ff[BIT_UNIT_EN]
                      && |(flags_ff[BIT_CMP0+3:BIT_CMP0] & irqen_ff[BIT_CMP0+3:BIT_CMP0]);
        capture_irq = irq_enable_register_one_ff[BIT_GLOB_EN] && irq_enable_register_one_ff[BIT_UNIT_EN]
                      && |(flags_ff[1:0] & irqen_ff[1:0]);
    end

endmodule : ccu_compare_capture

`default_nettype wire

// >>> src/ccu_pkg.sv
// Constants and types of the compare and capture unit.
package ccu_pkg;

    // ************************************************************
    // Register byte offsets on the APB bus.
    // ************************************************************
    localparam logic [7:0] OFS_CTRL0      = 8'h00;
    localparam logic [7:0] OFS_CMP0       = 8'h10;
    localparam logic [7:0] OFS_TCTRL1     = 8'h20;
    localparam logic [7:0] OFS_RELOAD     = 8'h24;
    localparam logic [7:0] OFS_FLAGS      = 8'h28;
    localparam logic [7:0] OFS_IRQEN      = 8'h2C;
    localparam logic [7:0] OFS_IRQ_ENABLE_REGISTER_ONE       = 8'h30;
    localparam logic [7:0] OFS_CAP_LO_A   = 8'h34;
    localparam logic [7:0] OFS_CAP_HI_A   = 8'h38;
    localparam logic [7:0] OFS_CAP_LO_B   = 8'h3C;
    localparam logic [7:0] OFS_CAP_HI_B   = 8'h40;

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int BIT_UPDATE   = 7;
    localparam int BIT_CAP_B    = 0;
    localparam int BIT_CAP_A    = 1;
    localparam int BIT_CMP0     = 2;
    localparam int BIT_UNIT_EN  = 4;
    localparam int BIT_GLOB_EN  = 7;

    // ************************************************************
    // Compare actions and timer modes.
    // ************************************************************
    localparam logic [1:0] ACT_OFF     = 2'h0;
    localparam logic [1:0] ACT_CLEAR   = 2'h1;
    localparam logic [1:0] ACT_INVALID = 2'h2;
    localparam logic [1:0] ACT_TOGGLE  = 2'h3;
    localparam logic [1:0] MODE_BASIC  = 2'h1;

    // ************************************************************
    // Reset values and filter length.
    // ************************************************************
    localparam logic [7:0]  RST_BYTE   = 8'h00;
    localparam logic [15:0] RST_WORD   = 16'h0000;
    localparam int          FILT_LEN   = 4;

    // Channel control register layout.
    typedef struct packed {
        logic [2:0] delay_code;
        logic       edge_sel;
        logic       filter_en;
        logic       force_cmp;
        logic [1:0] action;
    } ccu_chan_ctrl_type;

endpackage : ccu_pkg

// >>> test/ccu_compare_capture_monitor.sv
// Port-level checker of the compare and capture unit, bound to the design.
`timescale 1ns/1ps
`default_nettype none
module ccu_compare_capture_monitor
    import ccu_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        timer_step,
    input wire logic [1:0]  timer_mode,
    input wire logic [3:0]  compare_pin_out,
    input wire logic [3:0]  compare_pin_oe,
    input wire logic        compare_irq,
    input wire logic        capture_irq
);
    logic       wr_acc;
    logic       rd_acc;
    logic [7:0] ien_ff;

    // Decodes completed writes and basic-mode reads.
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite && !timer_mode[1];

    // Mirrors the global and unit enable byte.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            ien_ff <= 8'h00;
        else if (wr_acc && paddr == OFS_IRQ_ENABLE_REGISTER_ONE)
            ien_ff <= pwdata[7:0];
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // ****************************************************************
    // Properties.
    // ****************************************************************
    property p_oe_zero;
        (compare_pin_out & ~compare_pin_oe) == 4'h0;
    endproperty
    property p_pin_hold;
        !$stable(compare_pin_out) |-> $past(timer_step, 2) || $past(wr_acc);
    endproperty
    property p_oe_hold;
        !$stable(compare_pin_oe) |-> $past(wr_acc);
    endproperty
    property p_cmp_en;
        compare_irq |-> ien_ff[BIT_GLOB_EN] && ien_ff[BIT_UNIT_EN];
    endproperty
    property p_cap_en;
        capture_irq |-> ien_ff[BIT_GLOB_EN] && ien_ff[BIT_UNIT_EN];
    endproperty
    property p_irq_cause;
        $rose(compare_irq) |-> $past(timer_step, 2) || $past(wr_acc);
    endproperty
    property p_force_rd;
        rd_acc && paddr <= 8'h0C && paddr[1:0] == 2'h0 |-> !prdata[2];
    endproperty
    property p_upd_rd;
        rd_acc && paddr == OFS_TCTRL1 |-> !prdata[BIT_UPDATE];
    endproperty

    a_oe_zero: assert property (p_oe_zero) else $error("disabled pin driven");
    a_pin_hold: assert property (p_pin_hold) else $error("pin moved without cause");
    a_oe_hold: assert property (p_oe_hold) else $error("enable moved without write");
    a_cmp_en: assert property (p_cmp_en) else $error("compare irq not enabled");
    a_cap_en: assert property (p_cap_en) else $error("capture irq not enabled");
    a_irq_cause: assert property (p_irq_cause) else $error("compare irq without cause");
    a_force_rd: assert property (p_force_rd) else $error("force bit read one");
    a_upd_rd: assert property (p_upd_rd) else $error("update bit read one");

    c_cmp_irq: cover property ($rose(compare_irq));
    c_cap_irq: cover property ($rose(capture_irq));
    c_match: cover property (!$stable(compare_pin_out) && $past(timer_step, 2));
endmodule : ccu_compare_capture_monitor

bind ccu_compare_capture ccu_compare_capture_monitor u_monitor (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .timer_step(timer_step),
    .timer_mode(timer_mode), .compare_pin_out(compare_pin_out), .compare_pin_oe(compare_pin_oe),
    .compare_irq(compare_irq), .capture_irq(capture_irq)
);
`default_nettype wire

// >>> test/ccu_pin_model.sv
// External circuitry model on the compare and capture pins.
`timescale 1ns/1ps
`default_nettype none
module ccu_pin_model
(
    input  wire logic       core_clk,
    input  wire logic [3:0] compare_pin_out,
    input  wire logic [3:0] compare_pin_oe,
    input  wire logic [1:0] edge_drive,
    output logic      [1:0] capture_pin,
    output logic      [3:0] pin_level
);
    // Drives the capture pins just after each clock edge.
    always_ff @(posedge core_clk)
        capture_pin <= edge_drive;

    // An undriven compare pin rests at the pull-up.
    assign pin_level = (compare_pin_out & compare_pin_oe) | ~compare_pin_oe;
endmodule : ccu_pin_model
`default_nettype wire

// >>> test/ccu_compare_capture_test.sv
// Self-checking testbench of the compare and capture unit.
`timescale 1ns/1ps
`default_nettype none
module ccu_compare_capture_test import ccu_pkg::*;;
    typedef struct packed {logic [7:0] addr; logic [31:0] wdata; logic [31:0] exp;} ccu_row_type;
    logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, rerr;
    logic        timer_step, timer_overflow, compare_irq, capture_irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [15:0] timer_count, timer_reload_value;
    logic [1:0]  timer_mode, capture_pin, edge_drive;
    logic [3:0]  compare_pin_out, compare_pin_oe, pin_level;
    int          errors, checks, skip;
    localparam ccu_row_type ROWS [7] = '{
        '{OFS_CMP0, 32'h1234, 32'h1234}, '{OFS_CMP0 + 8'h04, 32'hABCD, 32'hABCD},
        '{OFS_RELOAD, 32'h5A5A, 32'h5A5A}, '{OFS_IRQEN, 32'h3B, 32'h3B}, '{OFS_IRQ_ENABLE_REGISTER_ONE, 32'h90, 32'h90},
        '{OFS_TCTRL1, 32'h80, 32'h0}, '{8'h44, 32'hFF, 32'h0}};

    ccu_compare_capture dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_count(timer_count), .timer_step(timer_step),
        .timer_overflow(timer_overflow), .timer_mode(timer_mode), .capture_pin(capture_pin),
        .compare_pin_out(compare_pin_out), .compare_pin_oe(compare_pin_oe), .compare_irq(compare_irq),
        .capture_irq(capture_irq), .timer_reload_value(timer_reload_value));
    ccu_pin_model u_pins (.core_clk(core_clk), .compare_pin_out(compare_pin_out),
        .compare_pin_oe(compare_pin_oe), .edge_drive(edge_drive), .capture_pin(capture_pin),
        .pin_level(pin_level));

    // ****************************************************************
    // Bus and comparison tasks.
    // ****************************************************************
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
            @(posedge core_clk);
        while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask : wr
    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0000_0000);
        chk(n, rdat, e);
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc
    task automatic tick(input logic [15:0] v);
        timer_count <= v;
        timer_step <= 1'b1;
        @(posedge core_clk);
        timer_step <= 1'b0;
        cyc(3);
    endtask : tick
    task automatic pulse_b();
        edge_drive[1] <= 1'b1;
        cyc(3);
        edge_drive[1] <= 1'b0;
        cyc(3);
    endtask : pulse_b
    task automatic conclude();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude

    // Makes the 100 MHz clock.
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Cuts a hung run short.
    initial
    begin
        cyc(20000);
        errors++;
        conclude();
    end

    // Runs the register table, then the hand-written cases.
    initial
    begin
        {rst, psel, penable, pwrite, timer_step, timer_overflow} = 6'h20;
        {paddr, pwdata, timer_count, edge_drive} = '0;
        timer_mode = MODE_BASIC;
        errors = 0;
        checks = 0;
        cyc(6);
        rst <= 1'b0;
        @(posedge core_clk);
        for (int a = 0; a <= 'h40; a += 4)
            rd("reset value", 8'(a), 32'h0);
        foreach (ROWS[i])
        begin
            wr(ROWS[i].addr, ROWS[i].wdata);
            rd("row readback", ROWS[i].addr, ROWS[i].exp);
            chk("row error", 32'(rerr), 32'(ROWS[i].addr > 8'h40));
        end
        chk("reload", 32'(timer_reload_value), 32'h5A5A);
        wr(OFS_CTRL0 + 8'h08, 32'h2);
        wr(OFS_CTRL0, 32'h3);
        wr(OFS_CTRL0 + 8'h04, 32'h1);
        chk("enables", 32'(compare_pin_oe), 32'h3);
        chk("pins", 32'(pin_level), 32'hC);
        tick(16'h1234);
        chk("toggle set", 32'(compare_pin_out), 32'h1);
        chk("masked irq", 32'(compare_irq), 32'h0);
        rd("flag a", OFS_FLAGS, 32'h4);
        tick(16'h1233);
        chk("hold", 32'(compare_pin_out), 32'h1);
        tick(16'h1234);
        chk("toggle clr", 32'(compare_pin_out), 32'h0);
        wr(OFS_CTRL0 + 8'h04, 32'h5);
        chk("force", 32'(compare_pin_out), 32'h2);
        rd("force flag", OFS_FLAGS, 32'h4);
        rd("force read", OFS_CTRL0 + 8'h04, 32'h1);
        tick(16'hABCD);
        chk("clear", 32'(compare_pin_out), 32'h0);
        chk("irq b", 32'(compare_irq), 32'h1);
        wr(OFS_FLAGS, 32'h3F);
        rd("flag one", OFS_FLAGS, 32'hC);
        wr(OFS_FLAGS, 32'h0);
        chk("irq clr", 32'(compare_irq), 32'h0);
        timer_mode <= 2'h2;
        wr(OFS_CMP0, 32'h1);
        wr(OFS_RELOAD, 32'h7777);
        wr(OFS_TCTRL1, 32'h80);
        rd("pending", OFS_TCTRL1, 32'h80);
        chk("held reload", 32'(timer_reload_value), 32'h5A5A);
        tick(16'h0001);
        chk("shadow only", 32'(compare_pin_out), 32'h0);
        timer_overflow <= 1'b1;
        @(posedge core_clk);
        timer_overflow <= 1'b0;
        @(posedge core_clk);
        rd("done", OFS_TCTRL1, 32'h0);
        chk("new reload", 32'(timer_reload_value), 32'h7777);
        timer_mode <= MODE_BASIC;
        tick(16'h0001);
        chk("new compare", 32'(compare_pin_out), 32'h1);
        timer_count <= 16'hBEEF;
        wr(OFS_CTRL0, 32'h13);
        wr(OFS_FLAGS, 32'h0);
        edge_drive[0] <= 1'b1;
        cyc(4);
        chk("cap irq", 32'(capture_irq), 32'h1);
        rd("cap lo", OFS_CAP_LO_A, 32'hEF);
        rd("cap flag", OFS_FLAGS, 32'h2);
        wr(OFS_FLAGS, 32'h0);
        edge_drive[0] <= 1'b0;
        cyc(4);
        rd("fall", OFS_FLAGS, 32'h0);
        timer_count <= 16'hC0DE;
        edge_drive[0] <= 1'b1;
        cyc(4);
        rd("shadow hi", OFS_CAP_HI_A, 32'hBE);
        rd("lo again", OFS_CAP_LO_A, 32'hDE);
        rd("hi again", OFS_CAP_HI_A, 32'hC0);
        for (int c = 0; c < 8; c++)
        begin
            skip = (c < 6) ? c : (c == 6) ? 7 : 15;
            wr(OFS_CTRL0 + 8'h04, {24'h0, 3'(c), 5'h10});
            wr(OFS_FLAGS, 32'h0);
            repeat (skip) pulse_b();
            rd("skipped", OFS_FLAGS, 32'h0);
            pulse_b();
            rd("delayed", OFS_FLAGS, 32'h1);
        end
        wr(OFS_CTRL0, 32'h18);
        edge_drive[0] <= 1'b0;
        cyc(12);
        wr(OFS_FLAGS, 32'h0);
        edge_drive[0] <= 1'b1;
        cyc(3);
        edge_drive[0] <= 1'b0;
        cyc(12);
        rd("glitch", OFS_FLAGS, 32'h0);
        edge_drive[0] <= 1'b1;
        cyc(16);
        rd("filtered", OFS_FLAGS, 32'h2);
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        @(posedge core_clk);
        chk("rst pins", 32'(compare_pin_out), 32'h0);
        chk("rst reload", 32'(timer_reload_value), 32'h0);
        rd("rst ctrl", OFS_CTRL0 + 8'h04, 32'h0);
        conclude();
    end
endmodule : ccu_compare_capture_test
`default_nettype wire
